// ===== core/acp_ctrl.v
// controller driving the multiplexed converter pins, with an axi4-lite register slave
// Operation
// - shared latch/start pulse is held high for more than 3 us.
// - start pulse comes from a write command.
// - channel latch strobe comes from a write command carrying the code.
// - a read of the result register pulses output-enable.
// - port access happens only on a decoded register access.
// - channel code travels in the low three data bits of the command.
// - channel code is driven on its own three select pins.
// - tied mode pulses latch and start together on one command.
// - output-enable stays high for OE_CYC cycles and falls as the result read is answered.
// - end-of-conversion state is visible to software directly.
// - a flag latches end-of-conversion and clears on result read.
// - select command pulses only the latch strobe with the channel code.
// - start command pulses start; result read pulses output-enable.
// - status bit zero reads low when conversion is complete.
// - end-of-conversion is ignored for a wait period after start.
// - result is fetched by the output-enable access after completion.
// - controller drives start, latch and output-enable and reads end-of-conversion.
// - converter clock is divided from the system clock.
// - rising end-of-conversion sets the flag; result read clears it.
// - combined command inserts a settle delay between latch and start when tied mode is off.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "acp_defs.vh"
module acp_ctrl #(
  parameter STRETCH_CYC = `ACP_STRETCH_CYC,
  parameter SETTLE_CYC = `ACP_SETTLE_CYC,
  parameter PULSE_CYC = `ACP_PULSE_CYC,
  parameter OE_CYC = `ACP_OE_CYC
) (
  input wire clk_sys, // system clock, 250 mhz
  input wire sys_rst, // async reset, active high
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output reg adc_clk, // converter clock
  output reg [2:0] adc_chan, // channel select pins
  output reg adc_ale, // channel latch strobe
  output reg adc_start, // start conversion pulse
  output reg adc_oe, // result output enable
  input wire [7:0] adc_data, // converter result bus
  input wire adc_eoc, // end of conversion
  output wire eoc_flag // latched end-of-conversion flag
);
  // sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_ALE = 3'h1;
  localparam ST_GAP = 3'h2;
  localparam ST_START = 3'h3;
  localparam ST_TIED = 3'h4;
  localparam ST_OE = 3'h5;

  // sequencer, mode and divider state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [11:0] cnt_r;
  reg [11:0] cnt_nxt;
  reg both_r;
  reg tied_r;
  reg [15:0] cdiv_r;
  reg [15:0] div_cnt_r;
  // pin synchronisers and end-of-conversion tracking
  reg eoc_s1_r;
  reg eoc_s2_r;
  reg eoc_d_r;
  reg [7:0] d_s1_r;
  reg [7:0] d_s2_r;
  reg flag_r;
  reg [3:0] wait_r;
  // result read held open while output-enable runs
  reg rd_pend_r;
  reg [7:0] rd_addr_r;

  // write taken only with address and data together, no response pending
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid && !rd_pend_r;
  wire busy = (state_r != ST_IDLE);
  // blanking window still counting after start
  wire armed = (wait_r != 4'h0);
  wire cclk_rise = (div_cnt_r == cdiv_r) && !adc_clk;
  wire eoc_done = eoc_s2_r && !armed;
  // commands ignored while the sequencer is busy
  // byte strobe 0 must be set for command writes
  wire cmd_wr = wr_go && (s_axi_awaddr == `ACP_OFF_CMD) && s_axi_wstrb[0] && !busy;
  wire [1:0] cmd_op = s_axi_wdata[`ACP_CMD_OP_HI:`ACP_CMD_OP_LO];
  wire data_rd = rd_go && (s_axi_araddr == `ACP_OFF_DATA) && !busy;
  // last cycle of the output-enable window
  wire oe_done = (state_r == ST_OE) && (cnt_r == 12'h000);
  wire start_fall = adc_start && (state_nxt != ST_START) && (state_nxt != ST_TIED);

  // handshakes combinational, data outputs registered
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign eoc_flag = flag_r;

  // sequencer for the latch, start and output-enable pins
  always @* begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 12'h000) ? 12'h000 : cnt_r - 12'h001;
    // one pin sequence at a time; reads and commands share it
    case (state_r)
      ST_IDLE: begin
        if (data_rd) begin
          state_nxt = ST_OE;
          cnt_nxt = OE_CYC[11:0] - 12'h001;
        end else if (cmd_wr && cmd_op == `ACP_OP_START) begin
          state_nxt = ST_START;
          cnt_nxt = PULSE_CYC[11:0] - 12'h001;
        end else if (cmd_wr && cmd_op == `ACP_OP_BOTH && tied_r) begin
          state_nxt = ST_TIED;
          cnt_nxt = STRETCH_CYC[11:0] - 12'h001;
        end else if (cmd_wr && cmd_op != 2'h0) begin
          state_nxt = ST_ALE;
          cnt_nxt = PULSE_CYC[11:0] - 12'h001;
        end
      end
      ST_ALE: begin
        if (cnt_r == 12'h000) begin
          if (both_r) begin
            state_nxt = ST_GAP;
            cnt_nxt = SETTLE_CYC[11:0] - 12'h001;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (cnt_r == 12'h000) begin
          state_nxt = ST_START;
          cnt_nxt = PULSE_CYC[11:0] - 12'h001;
        end
      end
      ST_START: begin
        if (cnt_r == 12'h000) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TIED: begin
        if (cnt_r == 12'h000) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_OE: begin
        if (cnt_r == 12'h000) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 12'h000;
      end
    endcase
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
      both_r <= 1'b0;
      adc_chan <= 3'h0;
      adc_ale <= 1'b0;
      adc_start <= 1'b0;
      adc_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // channel code kept until the next select or combined command
      if (state_r == ST_IDLE && cmd_wr) begin
        both_r <= (cmd_op == `ACP_OP_BOTH);
        if (cmd_op == `ACP_OP_SELECT || cmd_op == `ACP_OP_BOTH) begin
          adc_chan <= s_axi_wdata[2:0];
        end
      end

      // latch high on rise of the pulse, conversion begins on start fall
      adc_ale <= (state_nxt == ST_ALE) || (state_nxt == ST_TIED);
      adc_start <= (state_nxt == ST_START) || (state_nxt == ST_TIED);
      adc_oe <= (state_nxt == ST_OE);
    end
  end

  // converter clock divider
  // adc_clk toggles every cdiv_r+1 cycles and runs free
  // a divisor written below the count wraps at once
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_r <= 16'h0000;
      adc_clk <= 1'b0;
    end else if (div_cnt_r >= cdiv_r) begin
      div_cnt_r <= 16'h0000;
      adc_clk <= !adc_clk;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // pin synchronisers, blanking after start, end-of-conversion flag
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      // idle end-of-conversion is high: no false edge after reset
      eoc_s1_r <= 1'b1;
      eoc_s2_r <= 1'b1;
      eoc_d_r <= 1'b1;
      d_s1_r <= 8'h00;
      d_s2_r <= 8'h00;
      wait_r <= 4'h0;
      flag_r <= 1'b0;
    end else begin
      eoc_s1_r <= adc_eoc;
      eoc_s2_r <= eoc_s1_r;
      eoc_d_r <= eoc_done;
      // result bus sampled every cycle through two stages; the read takes d_s2_r in the last oe cycle
      d_s1_r <= adc_data;
      d_s2_r <= d_s1_r;

      // start fall arms the blanking window
      if (start_fall) begin
        wait_r <= `ACP_EOC_WAIT_PER;
      end else if (armed && cclk_rise) begin
        wait_r <= wait_r - 4'h1;
      end
      // set wins over a clear in the same cycle
      if (eoc_done && !eoc_d_r) begin
        flag_r <= 1'b1;
      end else if (oe_done) begin
        flag_r <= 1'b0;
      end
    end
  end

  // register slave
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      // separate strobes after reset
      tied_r <= `ACP_CTRL_RST;
      cdiv_r <= `ACP_CDIV_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACP_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ACP_RESP_OK;
      s_axi_rdata <= 32'h00000000;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 8'h00;
    end else begin
      // write channel
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ACP_RESP_OK;
        case (s_axi_awaddr)
          `ACP_OFF_CTRL: begin
            if (s_axi_wstrb[0]) begin
              tied_r <= s_axi_wdata[`ACP_CTRL_TIED];
            end
          end
          `ACP_OFF_CDIV: begin
            if (s_axi_wstrb[0]) begin
              cdiv_r[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
              cdiv_r[15:8] <= s_axi_wdata[15:8];
            end
          end
          `ACP_OFF_CMD: begin
          end
          default: begin
            s_axi_bresp <= `ACP_RESP_ERR;
          end
        endcase
      end

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (rd_pend_r) begin
        // answer only once the oe window has closed
        if (oe_done) begin
          rd_pend_r <= 1'b0;
          s_axi_rvalid <= 1'b1;
          s_axi_rdata <= {24'h000000, d_s2_r};
        end
      end else if (rd_go) begin
        rd_addr_r <= s_axi_araddr;
        s_axi_rresp <= `ACP_RESP_OK;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          `ACP_OFF_CTRL: begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata[`ACP_CTRL_TIED] <= tied_r;
          end
          `ACP_OFF_CMD: begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata[2:0] <= adc_chan;
          end
          `ACP_OFF_STAT: begin
            // status word built from live state
            s_axi_rvalid <= 1'b1;
            s_axi_rdata[`ACP_ST_EOC_N] <= !eoc_done;
            s_axi_rdata[`ACP_ST_FLAG] <= flag_r;
            s_axi_rdata[`ACP_ST_BUSY] <= busy;
            s_axi_rdata[`ACP_ST_ARMED] <= armed;
          end
          `ACP_OFF_CDIV: begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata[15:0] <= cdiv_r;
          end
          // result read refused while a pin sequence runs
          `ACP_OFF_DATA: begin
            if (busy) begin
              s_axi_rvalid <= 1'b1;
              s_axi_rresp <= `ACP_RESP_ERR;
            end else begin
              rd_pend_r <= 1'b1;
            end
          end
          default: begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ACP_RESP_ERR;
          end
        endcase
      end
    end
  end
endmodule

// ===== core/acp_defs.vh
// constants for the converter processor-port controller
`ifndef ACP_DEFS_VH
`define ACP_DEFS_VH
`define ACP_OFF_CTRL 8'h00
`define ACP_OFF_CMD 8'h04
`define ACP_OFF_STAT 8'h08
`define ACP_OFF_DATA 8'h0c
`define ACP_OFF_CDIV 8'h10
`define ACP_CTRL_TIED 0
`define ACP_CMD_OP_LO 4
`define ACP_CMD_OP_HI 5
`define ACP_OP_SELECT 2'h1
`define ACP_OP_START 2'h2
`define ACP_OP_BOTH 2'h3
`define ACP_ST_EOC_N 0
`define ACP_ST_FLAG 1
`define ACP_ST_BUSY 2
`define ACP_ST_ARMED 3
`define ACP_CTRL_RST 1'h0
`define ACP_CDIV_RST 16'h00c3
`define ACP_CLK_MHZ 250
`define ACP_STRETCH_NS 3000
`define ACP_STRETCH_CYC ((`ACP_STRETCH_NS * `ACP_CLK_MHZ) / 1000 + 1)
`define ACP_SETTLE_NS 3000
`define ACP_SETTLE_CYC ((`ACP_SETTLE_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_PULSE_NS 200
`define ACP_PULSE_CYC ((`ACP_PULSE_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_OE_NS 400
`define ACP_OE_CYC ((`ACP_OE_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_EOC_WAIT_PER 4'h8
`define ACP_RESP_OK 2'h0
`define ACP_RESP_ERR 2'h2
`endif

// ===== verification/acp_conv_model.sv
// behavioural multiplexed converter behind the pins
`timescale 1ns/10ps
module acp_conv_model (
  input wire adc_clk, // converter clock
  input wire [2:0] adc_chan, // select pins
  input wire adc_ale, // latch strobe
  input wire adc_start, // start pulse
  input wire adc_oe, // output enable
  output wire [7:0] adc_data, // result bus
  output reg adc_eoc // end of conversion
);
  reg [2:0] mux_r = 3'h0;
  reg [7:0] res_r = 8'h00;
  reg [7:0] last_r = 8'h00;
  integer cnt = -1;
  initial adc_eoc = 1'b1;
  always @(posedge adc_ale) mux_r <= adc_chan;
  always @(negedge adc_start) cnt <= 0;
  always @(posedge adc_clk) begin
    if (cnt >= 0) begin
      cnt <= cnt + 1;
      if (cnt == 2) adc_eoc <= 1'b0;
      if (cnt == 20) begin
        res_r <= 8'ha0 | {5'h00, mux_r};
        adc_eoc <= 1'b1;
        cnt <= -1;
      end
    end
  end
  // released bus shows inverse of last value
  always @(negedge adc_oe) last_r <= res_r;
  assign adc_data = adc_oe ? res_r : ~last_r;
endmodule

// ===== verification/acp_ctrl_chk.sv
// assertions on the converter port controller pins
`timescale 1ns/10ps
module acp_ctrl_chk #(
  parameter PULSE_CYC = 2,
  parameter STRETCH_CYC = 2,
  parameter OE_CYC = 2
) (
  input wire clk_sys, // clock
  input wire sys_rst, // reset
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_bvalid, // b valid
  input wire [7:0] s_axi_araddr, // ar address
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire [2:0] adc_chan, // select pins
  input wire adc_ale, // latch strobe
  input wire adc_start, // start pulse
  input wire adc_oe, // output enable
  input wire adc_eoc, // end of conversion
  input wire eoc_flag // latched flag
);
  reg [15:0] oe_cnt_r;
  reg [15:0] ale_cnt_r;
  // lengths of the current high phases
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oe_cnt_r <= 16'h0000;
      ale_cnt_r <= 16'h0000;
    end else begin
      oe_cnt_r <= adc_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
      ale_cnt_r <= adc_ale ? ale_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_oe_cause: assert property (
    $rose(adc_oe) |-> $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c))
    else $error("oe raised without a result read");
  chk_oe_width: assert property ($fell(adc_oe) |-> oe_cnt_r == OE_CYC)
    else $error("oe high for wrong length");
  chk_oe_answer: assert property ($fell(adc_oe) |-> s_axi_rvalid)
    else $error("result not answered at end of oe");
  chk_oe_quiet: assert property (
    adc_oe |-> !adc_ale && !adc_start && $stable(adc_chan))
    else $error("strobes or select moved during oe");
  chk_ale_width: assert property (
    $fell(adc_ale) && !$fell(adc_start) |-> ale_cnt_r == PULSE_CYC)
    else $error("latch pulse wrong length");
  chk_tied_width: assert property (
    $fell(adc_ale) && $fell(adc_start) |-> ale_cnt_r == STRETCH_CYC)
    else $error("shared pulse wrong length");
  chk_chan_hold: assert property (adc_ale && $past(adc_ale) |-> $stable(adc_chan))
    else $error("select changed while latching");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  chk_flag_set: assert property ($rose(eoc_flag) |-> $past(adc_eoc, 2))
    else $error("flag set without eoc");
  chk_flag_clear: assert property (
    $fell(adc_oe) && adc_eoc && $past(adc_eoc, 8) |-> !eoc_flag)
    else $error("flag not cleared by result read");
  cover property ($fell(adc_oe));
  cover property ($fell(adc_ale) && $fell(adc_start));
  cover property ($rose(eoc_flag));
endmodule
bind acp_ctrl acp_ctrl_chk #(.PULSE_CYC(PULSE_CYC), .STRETCH_CYC(STRETCH_CYC),
  .OE_CYC(OE_CYC)) i_acp_ctrl_chk (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .adc_chan,
  .adc_ale, .adc_start, .adc_oe, .adc_eoc, .eoc_flag);

// ===== verification/test_converter_cpu_port_glue.sv
// register-level test of the converter port controller
`timescale 1ns/10ps
`include "acp_defs.vh"
module test_converter_cpu_port_glue;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, adc_clk, adc_ale, adc_start, adc_oe;
  wire adc_eoc, eoc_flag;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] adc_chan;
  wire [7:0] adc_data;
  integer n_errors = 0, n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  acp_ctrl #(.STRETCH_CYC(6), .SETTLE_CYC(8), .PULSE_CYC(3), .OE_CYC(4)) i_acp_ctrl (
    .clk_sys, .sys_rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_clk,
    .adc_chan, .adc_ale, .adc_start, .adc_oe, .adc_data, .adc_eoc, .eoc_flag);
  acp_conv_model i_acp_conv_model (.adc_clk, .adc_chan, .adc_ale, .adc_start, .adc_oe,
    .adc_data, .adc_eoc);
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_sys); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp("bresp", er, bresp);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata;
    cmp("rdata", e, rdata & m);
    cmp("rresp", er, rresp);
  endtask
  task poll(input integer b, input logic v);
    integer i;
    rv[b] = ~v;
    for (i = 0; i < 200 && rv[b] !== v; i++) rd(`ACP_OFF_STAT, 0, 0, 0);
    cmp("status bit", v, rv[b]);
  endtask
  task conv(input logic [1:0] op, input logic [2:0] ch, input logic bz, input logic [7:0] ex);
    wr(`ACP_OFF_CMD, {26'h0, op, 1'b0, ch}, 0);
    if (bz) rd(`ACP_OFF_DATA, 0, 0, `ACP_RESP_ERR);
    poll(`ACP_ST_BUSY, 0);
    if (op != `ACP_OP_SELECT) begin
      cmp("eoc_n after start", 1, rv[`ACP_ST_EOC_N]);
      poll(`ACP_ST_EOC_N, 0);
      rd(`ACP_OFF_STAT, 32'h2, 32'h2, 0);
      cmp("eoc_flag", 1, eoc_flag);
      rd(`ACP_OFF_DATA, 32'hffffffff, {24'h0, ex}, 0);
      rd(`ACP_OFF_STAT, 32'h2, 32'h0, 0);
      cmp("eoc_flag", 0, eoc_flag);
    end
  endtask
  task give_verdict;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`ACP_OFF_CTRL, 32'hffffffff, `ACP_CTRL_RST, 0);
    rd(`ACP_OFF_CDIV, 32'hffff, `ACP_CDIV_RST, 0);
    wr(`ACP_OFF_CDIV, 1, 0);
    conv(`ACP_OP_SELECT, 5, 0, 0);
    conv(`ACP_OP_START, 0, 0, 8'ha5);
    conv(`ACP_OP_BOTH, 2, 1, 8'ha2);
    wr(`ACP_OFF_CTRL, 1, 0);
    conv(`ACP_OP_BOTH, 7, 0, 8'ha7);
    rd(`ACP_OFF_CMD, 32'h7, 32'h7, 0);
    wr(8'h14, 32'h5, `ACP_RESP_ERR);
    rd(8'h14, 32'hffffffff, 0, `ACP_RESP_ERR);
    give_verdict;
  end
endmodule
